// ==== occ_pkg.sv ====
package occ_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] FRACTION_HIGH_OFFSET = 8'h23;
	localparam logic [7:0] FRACTION_LOW_OFFSET = 8'h24;
	localparam logic [7:0] INT_DIVIDER_OFFSET = 8'h25;
	localparam logic [7:0] OUTPUT_CONTROL_OFFSET = 8'h26;
	localparam logic [7:0] MODULATION_CONTROL_OFFSET = 8'h27;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] FRACTION_HIGH_RESET = 16'h8000;
	localparam logic [15:0] FRACTION_LOW_RESET = 16'h0000;
	localparam logic [15:0] INT_DIVIDER_RESET = 16'h8003;
	localparam logic [15:0] OUTPUT_CONTROL_RESET = 16'h0009;
	localparam logic [15:0] MODULATION_CONTROL_RESET = 16'h0679;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int FRACTION_LOWER_MSB = 8;
	localparam int INTDIV_SOURCE_MSB = 15;
	localparam int INTDIV_SOURCE_LSB = 14;
	localparam int INTDIV_RATIO_MSB = 13;
	localparam int ALIGN_DELAY_MSB = 15;
	localparam int ALIGN_DELAY_LSB = 11;
	localparam int ALIGN_ENABLE_BIT = 10;
	localparam int SILENCE_POLARITY_BIT = 8;
	localparam int SILENCE_BIT = 7;
	localparam int CMOS_POLARITY_MSB = 6;
	localparam int CMOS_POLARITY_LSB = 5;
	localparam int BUFFER_FORMAT_MSB = 4;
	localparam int BUFFER_FORMAT_LSB = 2;
	localparam int OUTPUT_SELECT_MSB = 1;
	localparam int DELAY_MODE_BIT = 15;
	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [1:0] SOURCE_PRESCALER_A = 2'h0;
	localparam logic [1:0] SOURCE_PRESCALER_B = 2'h1;
	localparam logic [1:0] SOURCE_FRACTIONAL = 2'h2;
	localparam logic [1:0] SOURCE_REFERENCE = 2'h3;
	localparam logic [2:0] FORMAT_DISABLED = 3'h0;
	localparam logic [2:0] FORMAT_LVDS = 3'h1;
	localparam logic [2:0] FORMAT_HCSL = 3'h2;
	localparam logic [2:0] FORMAT_CML = 3'h3;
	localparam logic [2:0] FORMAT_LVPECL = 3'h4;
	typedef enum logic [0:0] {
		ALIGN_IDLE = 1'b0,
		ALIGN_COUNT = 1'b1
	} occ_align_type;
endpackage

// ==== occ_config.sv ====
`timescale 1ns/1ps
// Operation
// - Upper fraction register, reset 8000h
// - Lower nine fraction bits, reset zero
// - Integer divider source select, reset fractional
// - Fourteen-bit ratio divides; zero powers down
// - Align delay counts selected source clocks
// - Align only when enable bit set
// - Silence polarity sets muted output levels
// - Override mutes directly, else during calibration
// - Buffer format decode, reset HCSL
module occ_config (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Source clock enables
	input wire logic prescaler_a_tick,
	input wire logic prescaler_b_tick,
	input wire logic fraction_tick,
	input wire logic reference_tick,
	// Device state
	input wire logic operation_override,
	input wire logic calibration_active,
	input wire logic align_request,
	// Divider and alignment
	output logic intdiv_tick,
	output logic intdiv_powerdown,
	output logic align_done,
	// Output stage
	output logic mute_active,
	output logic out_p_level,
	output logic out_n_level,
	output logic buffer_disabled,
	// Configuration fields
	output logic [15:0] chan1_fraction_upper,
	output logic [8:0] chan1_fraction_lower,
	output logic fraction_delay_mode,
	output logic [2:0] chan1_buffer_format,
	output logic [1:0] chan1_output_select,
	output logic [1:0] chan1_cmos_polarity,
	output logic [15:0] modulation_bits
);
	// ****************************************
	// Register storage
	// ****************************************
	logic [15:0] frac_high_ff;
	logic [15:0] frac_low_ff;
	logic [15:0] int_div_ff;
	logic [15:0] out_ctrl_ff;
	logic [15:0] mod_ctrl_ff;
	logic [15:0] rdata_ff;
	wire hit_frac_high = reg_addr == occ_pkg::FRACTION_HIGH_OFFSET;
	wire hit_frac_low = reg_addr == occ_pkg::FRACTION_LOW_OFFSET;
	wire hit_int_div = reg_addr == occ_pkg::INT_DIVIDER_OFFSET;
	wire hit_out_ctrl = reg_addr == occ_pkg::OUTPUT_CONTROL_OFFSET;
	wire hit_mod_ctrl = reg_addr == occ_pkg::MODULATION_CONTROL_OFFSET;
	logic [15:0] nxt_rdata;
	always_comb begin
		if (hit_frac_high) begin
			nxt_rdata = frac_high_ff;
		end else if (hit_frac_low) begin
			nxt_rdata = frac_low_ff;
		end else if (hit_int_div) begin
			nxt_rdata = int_div_ff;
		end else if (hit_out_ctrl) begin
			nxt_rdata = out_ctrl_ff;
		end else if (hit_mod_ctrl) begin
			nxt_rdata = mod_ctrl_ff;
		end else begin
			nxt_rdata = 16'h0000;
		end
	end
	// Reserved bits are stored so they read back as written
	always_ff @(posedge clock) begin
		if (srst) begin
			frac_high_ff <= occ_pkg::FRACTION_HIGH_RESET;
			frac_low_ff <= occ_pkg::FRACTION_LOW_RESET;
			int_div_ff <= occ_pkg::INT_DIVIDER_RESET;
			out_ctrl_ff <= occ_pkg::OUTPUT_CONTROL_RESET;
			mod_ctrl_ff <= occ_pkg::MODULATION_CONTROL_RESET;
		end else if (reg_wr) begin
			if (hit_frac_high) frac_high_ff <= reg_wdata;
			if (hit_frac_low) frac_low_ff <= reg_wdata;
			if (hit_int_div) int_div_ff <= reg_wdata;
			if (hit_out_ctrl) out_ctrl_ff <= reg_wdata;
			if (hit_mod_ctrl) mod_ctrl_ff <= reg_wdata;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_ff <= 16'h0000;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata = rdata_ff;
	// ****************************************
	// Field decode
	// ****************************************
	wire [1:0] intdiv_source = int_div_ff[occ_pkg::INTDIV_SOURCE_MSB:occ_pkg::INTDIV_SOURCE_LSB];
	wire [13:0] intdiv_ratio = int_div_ff[occ_pkg::INTDIV_RATIO_MSB:0];
	wire [4:0] align_delay = out_ctrl_ff[occ_pkg::ALIGN_DELAY_MSB:occ_pkg::ALIGN_DELAY_LSB];
	wire align_enable = out_ctrl_ff[occ_pkg::ALIGN_ENABLE_BIT];
	wire silence_polarity = out_ctrl_ff[occ_pkg::SILENCE_POLARITY_BIT];
	wire silence = out_ctrl_ff[occ_pkg::SILENCE_BIT];
	assign chan1_fraction_upper = frac_high_ff;
	assign chan1_fraction_lower = frac_low_ff[occ_pkg::FRACTION_LOWER_MSB:0];
	assign fraction_delay_mode = mod_ctrl_ff[occ_pkg::DELAY_MODE_BIT];
	assign chan1_buffer_format = out_ctrl_ff[occ_pkg::BUFFER_FORMAT_MSB:occ_pkg::BUFFER_FORMAT_LSB];
	assign chan1_output_select = out_ctrl_ff[occ_pkg::OUTPUT_SELECT_MSB:0];
	assign chan1_cmos_polarity = out_ctrl_ff[occ_pkg::CMOS_POLARITY_MSB:occ_pkg::CMOS_POLARITY_LSB];
	assign modulation_bits = mod_ctrl_ff;
	assign buffer_disabled = chan1_buffer_format == occ_pkg::FORMAT_DISABLED;
	// ****************************************
	// Source select and integer divider
	// ****************************************
	wire sel_tick = (intdiv_source == occ_pkg::SOURCE_PRESCALER_A) ? prescaler_a_tick :
		(intdiv_source == occ_pkg::SOURCE_PRESCALER_B) ? prescaler_b_tick :
		(intdiv_source == occ_pkg::SOURCE_FRACTIONAL) ? fraction_tick :
		reference_tick;
	assign intdiv_powerdown = intdiv_ratio == 14'h0000;
	logic [13:0] div_cnt_ff;
	logic div_tick_ff;
	wire div_wrap = div_cnt_ff >= intdiv_ratio - 14'h0001;
	// Alignment restarts the divider so all channels share phase
	always_ff @(posedge clock) begin
		if (srst || intdiv_powerdown || align_done) begin
			div_cnt_ff <= 14'h0000;
			div_tick_ff <= 1'b0;
		end else if (sel_tick) begin
			div_cnt_ff <= div_wrap ? 14'h0000 : div_cnt_ff + 14'h0001;
			div_tick_ff <= div_wrap;
		end else begin
			div_tick_ff <= 1'b0;
		end
	end
	assign intdiv_tick = div_tick_ff;
	// ****************************************
	// Alignment delay
	// ****************************************
	occ_pkg::occ_align_type state_ff;
	occ_pkg::occ_align_type nxt_state;
	logic [4:0] delay_cnt_ff;
	logic [4:0] nxt_delay_cnt;
	logic done_ff;
	logic nxt_done;
	always_comb begin
		nxt_state = state_ff;
		nxt_delay_cnt = delay_cnt_ff;
		nxt_done = 1'b0;
		case (state_ff)
			occ_pkg::ALIGN_IDLE: begin
				if (align_request && align_enable) begin
					if (align_delay == 5'h00) begin
						nxt_done = 1'b1;
					end else begin
						nxt_state = occ_pkg::ALIGN_COUNT;
						nxt_delay_cnt = align_delay;
					end
				end
			end
			occ_pkg::ALIGN_COUNT: begin
				if (sel_tick) begin
					nxt_delay_cnt = delay_cnt_ff - 5'h01;
					if (delay_cnt_ff == 5'h01) begin
						nxt_done = 1'b1;
						nxt_state = occ_pkg::ALIGN_IDLE;
					end
				end
			end
			default: nxt_state = occ_pkg::ALIGN_IDLE;
		endcase
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff <= occ_pkg::ALIGN_IDLE;
			delay_cnt_ff <= 5'h00;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			delay_cnt_ff <= nxt_delay_cnt;
			done_ff <= nxt_done;
		end
	end
	assign align_done = done_ff;
	// ****************************************
	// Mute
	// ****************************************
	assign mute_active = operation_override ? silence : (silence && calibration_active);
	assign out_p_level = mute_active & silence_polarity;
	assign out_n_level = mute_active & ~silence_polarity;
	// ****************************************
	// Checks
	// ****************************************
	property p_upper_write;
		@(posedge clock) disable iff (srst)
		(reg_wr && hit_frac_high) |=> chan1_fraction_upper == $past(reg_wdata);
	endproperty
	a_upper_write: assert property (p_upper_write) else $error("upper fraction not written");
	property p_lower_reset;
		@(posedge clock) disable iff (srst)
		$past(srst) |-> (chan1_fraction_lower == 9'h000 && chan1_fraction_upper == 16'h8000);
	endproperty
	a_lower_reset: assert property (p_lower_reset) else $error("fraction reset wrong");
	property p_source_sel;
		@(posedge clock) disable iff (srst)
		(intdiv_source == occ_pkg::SOURCE_FRACTIONAL && !fraction_tick) |=> !intdiv_tick;
	endproperty
	a_source_sel: assert property (p_source_sel) else $error("source select wrong");
	property p_powerdown;
		@(posedge clock) disable iff (srst)
		(intdiv_ratio == 14'h0000) |=> !intdiv_tick;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("divider ticks while down");
	property p_zero_delay;
		@(posedge clock) disable iff (srst)
		(state_ff == occ_pkg::ALIGN_IDLE && align_request && align_enable && align_delay == 5'h00)
			|=> align_done;
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay align missing");
	property p_align_gate;
		@(posedge clock) disable iff (srst)
		(state_ff == occ_pkg::ALIGN_IDLE && !(align_request && align_enable)) |=> !align_done;
	endproperty
	a_align_gate: assert property (p_align_gate) else $error("align without enable");
	property p_mute_levels;
		@(posedge clock) disable iff (srst)
		(mute_active && !silence_polarity) |-> (!out_p_level && out_n_level);
	endproperty
	a_mute_levels: assert property (p_mute_levels) else $error("mute levels wrong");
	property p_override;
		@(posedge clock) disable iff (srst)
		(!operation_override && !calibration_active) |-> !mute_active;
	endproperty
	a_override: assert property (p_override) else $error("mute outside calibration");
	property p_format;
		@(posedge clock) disable iff (srst)
		$past(srst) |-> (chan1_buffer_format == 3'h2 && !buffer_disabled);
	endproperty
	a_format: assert property (p_format) else $error("buffer format reset wrong");
	property p_reg_reset;
		@(posedge clock) disable iff (srst)
		$past(srst) |-> (int_div_ff == 16'h8003 && out_ctrl_ff == 16'h0009 && mod_ctrl_ff == 16'h0679);
	endproperty
	a_reg_reset: assert property (p_reg_reset) else $error("register reset wrong");
endmodule

// ==== occ_config_test.sv ====
`timescale 1ns/1ps
module occ_config_test;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [3:0] tk = 4'h0;
	logic ovrd = 1'b0;
	logic cal = 1'b0;
	logic areq = 1'b0;
	logic intdiv_tick, intdiv_powerdown, align_done, mute_active;
	logic out_p_level, out_n_level, buffer_disabled;
	logic [15:0] fr_up;
	logic [8:0] fr_lo;
	logic [2:0] fmt;
	logic [1:0] osel;
	logic [1:0] cpol;
	logic dmode;
	logic [15:0] mbits;
	logic [15:0] rv;
	int n_mismatch = 0;
	int num_checks = 0;
	int c_div;
	int c_aln;

	always #12.5 clock = ~clock;

	occ_config uut (
		.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.prescaler_a_tick(tk[0]), .prescaler_b_tick(tk[1]),
		.fraction_tick(tk[2]), .reference_tick(tk[3]),
		.operation_override(ovrd), .calibration_active(cal), .align_request(areq),
		.intdiv_tick(intdiv_tick), .intdiv_powerdown(intdiv_powerdown),
		.align_done(align_done), .mute_active(mute_active),
		.out_p_level(out_p_level), .out_n_level(out_n_level),
		.buffer_disabled(buffer_disabled), .chan1_fraction_upper(fr_up),
		.chan1_fraction_lower(fr_lo), .fraction_delay_mode(dmode),
		.chan1_buffer_format(fmt), .chan1_output_select(osel),
		.chan1_cmos_polarity(cpol), .modulation_bits(mbits)
	);

	// ****************************************
	// Access and compare tasks
	// ****************************************
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task do_reset;
		@(posedge clock);
		srst <= 1'b1;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask

	task rchk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// Ticks n cycles on mask m; align count adds on to align_pulse's
	task run(input logic [3:0] m, input int n);
		c_div = 0;
		for (int i = 0; i < n + 2; i++) begin
			@(posedge clock);
			tk <= (i < n) ? m : 4'h0;
			#1;
			c_div += int'(intdiv_tick === 1'b1);
			c_aln += int'(align_done === 1'b1);
		end
	endtask

	// Zero delay answers one clock after the request, before run samples, so look here too
	task align_pulse;
		c_aln = 0;
		@(posedge clock);
		areq <= 1'b1;
		@(posedge clock);
		areq <= 1'b0;
		#1;
		c_aln = int'(align_done === 1'b1);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		do_reset;
		rchk(occ_pkg::FRACTION_HIGH_OFFSET, 16'h8000);
		rchk(occ_pkg::FRACTION_LOW_OFFSET, 16'h0000);
		rchk(occ_pkg::INT_DIVIDER_OFFSET, 16'h8003);
		rchk(occ_pkg::OUTPUT_CONTROL_OFFSET, 16'h0009);
		rchk(occ_pkg::MODULATION_CONTROL_OFFSET, 16'h0679);
		chk(mbits, 16'h0679);
		chk({11'h000, dmode, cpol, osel}, 16'h0001);
		wr(8'h28, 16'hFFFF);
		rchk(8'h28, 16'h0000);
		wr(occ_pkg::FRACTION_LOW_OFFSET, 16'hFFFF);
		chk(16'(fr_lo), 16'h01FF);
		rchk(occ_pkg::FRACTION_LOW_OFFSET, 16'hFFFF);
		wr(occ_pkg::FRACTION_HIGH_OFFSET, 16'h1234);
		chk(fr_up, 16'h1234);
		wr(occ_pkg::MODULATION_CONTROL_OFFSET, 16'h8000);
		chk({15'h0000, dmode}, 16'h0001);
		wr(occ_pkg::OUTPUT_CONTROL_OFFSET, 16'h0062);
		chk({12'h000, cpol, osel}, 16'h000E);
		$display("test registers done");
		// Reset per source so no leftover count skews the pulse total
		for (int s = 0; s < 4; s++) begin
			do_reset;
			wr(occ_pkg::INT_DIVIDER_OFFSET, {2'(s), 14'h0003});
			run(~(4'h1 << s), 6);
			chk(16'(c_div), 16'h0000);
			run(4'h1 << s, 6);
			chk(16'(c_div), 16'h0002);
		end
		rchk(occ_pkg::FRACTION_LOW_OFFSET, 16'h0000);
		wr(occ_pkg::INT_DIVIDER_OFFSET, 16'h8000);
		chk(16'(intdiv_powerdown), 16'h0001);
		run(4'hF, 6);
		chk(16'(c_div), 16'h0000);
		$display("test divider done");
		wr(occ_pkg::OUTPUT_CONTROL_OFFSET, 16'h1009);
		align_pulse;
		run(4'h4, 4);
		chk(16'(c_aln), 16'h0000);
		wr(occ_pkg::OUTPUT_CONTROL_OFFSET, 16'h1409);
		align_pulse;
		run(4'h4, 1);
		chk(16'(c_aln), 16'h0000);
		run(4'h4, 1);
		chk(16'(c_aln), 16'h0001);
		wr(occ_pkg::OUTPUT_CONTROL_OFFSET, 16'h0409);
		align_pulse;
		run(4'h0, 0);
		chk(16'(c_aln), 16'h0001);
		$display("test align done");
		for (int i = 0; i < 16; i++) begin
			@(posedge clock);
			ovrd <= i[3];
			cal <= i[2];
			wr(occ_pkg::OUTPUT_CONTROL_OFFSET, 16'h0009 | (16'(i[1]) << 7) | (16'(i[0]) << 8));
			rv = 16'(i[1] & (i[3] | i[2]));
			chk({13'h0, mute_active, out_p_level, out_n_level},
				{13'h0, rv[0], rv[0] & i[0], rv[0] & ~i[0]});
		end
		$display("test mute done");
		for (int f = 0; f < 5; f++) begin
			wr(occ_pkg::OUTPUT_CONTROL_OFFSET, 16'h0001 | (16'(f) << 2));
			chk({12'h0, buffer_disabled, fmt}, {12'h0, f == 0, 3'(f)});
		end
		$display("test format done");
		stop_test;
	end

	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		stop_test;
	end
endmodule
